// ===== src/ofe_ctrl.sv
// Purpose: oscillator force-enable register, sleep regulator mode control
// Assumes: single hclk domain; sleep and wake requests come from core logic
// Notes:   oscillator enables are force bit or peripheral request
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ofe_ctrl (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [5:0] periph_osc_req,
	input wire logic sleep_req,
	input wire logic wake_req,
	output ofe_pkg::ofe_osc_t osc_enable,
	output logic secondary_osc_use_power_cfg,
	output logic regulator_enable,
	output logic regulator_low_power,
	output logic core_hold
);
	import ofe_pkg::*;

	// ----------------------------------------------------------------
	// bus address phase capture
	// ----------------------------------------------------------------
	ofe_ahb_req_t req, next_req;
	logic [7:0] osc_force, next_osc_force;
	logic [7:0] reg_ctrl, next_reg_ctrl;
	logic [31:0] next_hrdata;
	ofe_state_t state, next_state;
	logic [7:0] wake_cnt, next_wake_cnt;
	logic [5:0] req_s1, req_s2;
	logic sleep_s1, sleep_s2, wake_s1, wake_s2;
	ofe_osc_t next_osc_enable;
	logic next_sec_cfg, next_reg_lp;
	logic next_core_hold;

	function automatic logic [31:0] rd_mux(input logic [11:0] a,
			input logic [7:0] f, input logic [7:0] c,
			input ofe_state_t s);
		case (a)
			ofe_osc_force_off: rd_mux = {24'h00_0000, f};
			ofe_reg_ctrl_off: rd_mux = {24'h00_0000, c};
			ofe_status_off: rd_mux = {28'h000_0000, s};
			default: rd_mux = 32'h0000_0000;
		endcase
	endfunction

	always_comb begin
		next_req = req;
		if (hready) begin
			next_req.sel = hsel && htrans[1];
			next_req.write = hwrite;
			next_req.trans = htrans;
			next_req.addr = haddr[11:0];
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_comb begin
		next_osc_force = osc_force;
		next_reg_ctrl = reg_ctrl;
		next_hrdata = hrdata;
		if (req.sel && req.write) begin
			if (req.addr == ofe_osc_force_off)
				next_osc_force = hwdata[7:0] & ofe_osc_force_mask;
			if (req.addr == ofe_reg_ctrl_off)
				next_reg_ctrl = {6'h00, hwdata[ofe_pm_bit], 1'b0};
		end
		// forwarded values: a read right behind a write sees the new word
		if (hready && hsel && htrans[1] && !hwrite)
			next_hrdata = rd_mux(haddr[11:0], next_osc_force,
				next_reg_ctrl, state);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req <= '0;
			osc_force <= ofe_osc_force_rst;
			reg_ctrl <= ofe_reg_ctrl_rst;
			hrdata <= 32'h0000_0000;
		end else begin
			req <= next_req;
			osc_force <= next_osc_force;
			reg_ctrl <= next_reg_ctrl;
			hrdata <= next_hrdata;
		end
	end

	// ----------------------------------------------------------------
	// register checks
	// ----------------------------------------------------------------
	chk_force_reserved: assert property (
		@(posedge hclk) disable iff (!hresetn)
		osc_force[1:0] == 2'b00) else $error("force bits 1:0 set");
	chk_force_write: assert property (
		@(posedge hclk) disable iff (!hresetn)
		req.sel && req.write && req.addr == ofe_osc_force_off
		|=> osc_force == ($past(hwdata[7:0]) & ofe_osc_force_mask))
		else $error("force write lost");
	// other writes must leave the force bits alone
	chk_force_hold: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!(req.sel && req.write && req.addr == ofe_osc_force_off)
		|=> $stable(osc_force)) else $error("force bits changed");
	// a read in the cycle after a write must return the new word
	chk_force_read: assert property (
		@(posedge hclk) disable iff (!hresetn)
		hready && hsel && htrans[1] && !hwrite
		&& haddr[11:0] == ofe_osc_force_off
		|=> hrdata == {24'h00_0000, osc_force})
		else $error("force read wrong");
	chk_ctrl_write: assert property (
		@(posedge hclk) disable iff (!hresetn)
		req.sel && req.write && req.addr == ofe_reg_ctrl_off
		|=> reg_ctrl[ofe_pm_bit] == $past(hwdata[ofe_pm_bit]))
		else $error("mode select write lost");
	chk_ctrl_hold: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!(req.sel && req.write && req.addr == ofe_reg_ctrl_off)
		|=> $stable(reg_ctrl)) else $error("mode select changed");
	chk_ctrl_reserved: assert property (
		@(posedge hclk) disable iff (!hresetn)
		reg_ctrl[7:2] == 6'h00 && !reg_ctrl[0])
		else $error("ctrl spare bits set");
	chk_ctrl_read: assert property (
		@(posedge hclk) disable iff (!hresetn)
		hready && hsel && htrans[1] && !hwrite
		&& haddr[11:0] == ofe_reg_ctrl_off
		|=> hrdata == {24'h00_0000, reg_ctrl})
		else $error("mode select read wrong");

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_s1 <= 6'h00;
			req_s2 <= 6'h00;
			sleep_s1 <= 1'b0;
			sleep_s2 <= 1'b0;
			wake_s1 <= 1'b0;
			wake_s2 <= 1'b0;
		end else begin
			req_s1 <= periph_osc_req;
			req_s2 <= req_s1;
			sleep_s1 <= sleep_req;
			sleep_s2 <= sleep_s1;
			wake_s1 <= wake_req;
			wake_s2 <= wake_s1;
		end
	end

	// ----------------------------------------------------------------
	// sleep sequencer and outputs
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_wake_cnt = wake_cnt;
		case (state)
			ofe_run: begin
				if (sleep_s2)
					next_state = reg_ctrl[ofe_pm_bit] ? ofe_sleep_lp
						: ofe_sleep_norm;
			end
			ofe_sleep_norm: begin
				if (wake_s2)
					next_state = ofe_run;
			end
			ofe_sleep_lp: begin
				if (wake_s2) begin
					next_state = ofe_wake_wait;
					next_wake_cnt = ofe_wake_cnt;
				end
			end
			ofe_wake_wait: begin
				if (wake_cnt <= 8'h01)
					next_state = ofe_run;
				next_wake_cnt = wake_cnt - 8'h01;
			end
			default: next_state = ofe_run;
		endcase
		next_osc_enable = ofe_osc_t'(osc_force[7:2] | req_s2);
		next_sec_cfg = osc_force[ofe_sec_bit];
		next_reg_lp = (next_state == ofe_sleep_lp);
		next_core_hold = (next_state != ofe_run);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ofe_run;
			wake_cnt <= 8'h00;
			osc_enable <= '0;
			secondary_osc_use_power_cfg <= 1'b0;
			regulator_low_power <= 1'b0;
			regulator_enable <= 1'b1;
			core_hold <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			state <= next_state;
			wake_cnt <= next_wake_cnt;
			osc_enable <= next_osc_enable;
			secondary_osc_use_power_cfg <= next_sec_cfg;
			regulator_low_power <= next_reg_lp;
			regulator_enable <= 1'b1;
			core_hold <= next_core_hold;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// wake delay watch
	// ----------------------------------------------------------------
	// own count of hold cycles after a low-power wake, so the delay
	// check does not lean on the sequencer's counter
	logic [7:0] lp_hold_cnt, next_lp_hold_cnt;
	logic lp_waking, next_lp_waking;

	always_comb begin
		next_lp_hold_cnt = lp_hold_cnt;
		next_lp_waking = lp_waking;
		if (state == ofe_sleep_lp && wake_s2) begin
			next_lp_waking = 1'b1;
			next_lp_hold_cnt = 8'h00;
		end else if (lp_waking) begin
			if (core_hold)
				next_lp_hold_cnt = lp_hold_cnt + 8'h01;
			else
				next_lp_waking = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lp_hold_cnt <= 8'h00;
			lp_waking <= 1'b0;
		end else begin
			lp_hold_cnt <= next_lp_hold_cnt;
			lp_waking <= next_lp_waking;
		end
	end

	// ----------------------------------------------------------------
	// sequencer checks
	// ----------------------------------------------------------------
	chk_osc_enable: assert property (
		@(posedge hclk) disable iff (!hresetn)
		##1 osc_enable == ofe_osc_t'($past(osc_force[7:2] | req_s2)))
		else $error("osc enable wrong");
	chk_sec_power: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$rose(osc_force[ofe_sec_bit]) |=> secondary_osc_use_power_cfg
		&& osc_enable.secondary_osc) else $error("secondary not kept");
	chk_sec_follow: assert property (
		@(posedge hclk) disable iff (!hresetn)
		##1 secondary_osc_use_power_cfg == $past(osc_force[ofe_sec_bit]))
		else $error("secondary power setting lost");
	chk_lp_entry: assert property (
		@(posedge hclk) disable iff (!hresetn)
		state == ofe_run && sleep_s2 && !reg_ctrl[ofe_pm_bit]
		|=> !regulator_low_power) else $error("lp without select");
	chk_lp_select: assert property (
		@(posedge hclk) disable iff (!hresetn)
		state == ofe_run && sleep_s2 && reg_ctrl[ofe_pm_bit]
		|=> regulator_low_power) else $error("lp not entered");
	chk_lp_state: assert property (
		@(posedge hclk) disable iff (!hresetn)
		regulator_low_power == (state == ofe_sleep_lp))
		else $error("lp outside lp sleep");
	chk_lp_stay: assert property (
		@(posedge hclk) disable iff (!hresetn)
		state == ofe_sleep_lp && !wake_s2 |=> regulator_low_power)
		else $error("lp left while asleep");
	chk_reg_on: assert property (
		@(posedge hclk) disable iff (!hresetn)
		regulator_enable) else $error("regulator off");
	chk_lp_wake: assert property (
		@(posedge hclk) disable iff (!hresetn)
		state == ofe_sleep_lp && wake_s2 |=> core_hold [*8])
		else $error("lp wake too soon");
	// hold must fall exactly one full delay after the wake was seen
	chk_wake_len: assert property (
		@(posedge hclk) disable iff (!hresetn)
		lp_waking && !core_hold |-> lp_hold_cnt == ofe_wake_cnt)
		else $error("lp wake delay wrong length");
	chk_norm_wake: assert property (
		@(posedge hclk) disable iff (!hresetn)
		state == ofe_sleep_norm && wake_s2 |=> !core_hold)
		else $error("normal wake delayed");
	chk_norm_no_wait: assert property (
		@(posedge hclk) disable iff (!hresetn)
		state == ofe_sleep_norm |=> state != ofe_wake_wait)
		else $error("normal wake waited");
	chk_wait_from_lp: assert property (
		@(posedge hclk) disable iff (!hresetn)
		state == ofe_wake_wait && $past(state) != ofe_wake_wait
		|-> $past(state) == ofe_sleep_lp) else $error("wait not from lp");
	chk_hold_state: assert property (
		@(posedge hclk) disable iff (!hresetn)
		core_hold == (state != ofe_run)) else $error("hold mismatch");
endmodule
`default_nettype wire

// ===== src/ofe_pkg.sv
// Purpose: constants and types for the oscillator force-enable and sleep
//          regulator control block
// Assumes: AHB-Lite slave, 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
// Function
// - bits 7..2 force six oscillators on; clear means peripheral request only
// - secondary force keeps it running at its own configured power setting
// - low-power sleep regulator only when power-mode select bit is set
// - regulator and reference stay enabled throughout sleep in every mode
// - wake from low-power sleep waits extra stabilization delay
package ofe_pkg;
	localparam logic [11:0] ofe_osc_force_off = 12'h000;
	localparam logic [11:0] ofe_reg_ctrl_off = 12'h004;
	localparam logic [11:0] ofe_status_off = 12'h008;
	localparam logic [7:0] ofe_osc_force_rst = 8'h00;
	localparam logic [7:0] ofe_osc_force_mask = 8'hfc;
	localparam int ofe_ext_bit = 7;
	localparam int ofe_high_bit = 6;
	localparam int ofe_med_bit = 5;
	localparam int ofe_low_bit = 4;
	localparam int ofe_sec_bit = 3;
	localparam int ofe_conv_bit = 2;
	localparam int ofe_pm_bit = 1;
	localparam logic [7:0] ofe_reg_ctrl_rst = 8'h00;
	// extra wake delay in ns and in hclk cycles (40 MHz, rounded up)
	localparam int ofe_clk_ns = 25;
	localparam int ofe_wake_ns = 1000;
	localparam int ofe_wake_cyc = (ofe_wake_ns + ofe_clk_ns - 1) / ofe_clk_ns;
	localparam logic [7:0] ofe_wake_cnt = 8'(ofe_wake_cyc);

	typedef enum logic [3:0] {
		ofe_run = 4'b0001,
		ofe_sleep_norm = 4'b0010,
		ofe_sleep_lp = 4'b0100,
		ofe_wake_wait = 4'b1000
	} ofe_state_t;

	typedef struct packed {
		logic external_osc;
		logic high_internal_osc;
		logic medium_internal_osc;
		logic low_internal_osc;
		logic secondary_osc;
		logic converter_osc;
	} ofe_osc_t;

	typedef struct packed {
		logic sel;
		logic write;
		logic [1:0] trans;
		logic [11:0] addr;
	} ofe_ahb_req_t;
endpackage

// ===== testbench/oscillator_force_enable_sleep_ctrl_test.sv
// Purpose: register and sleep checks of the oscillator force block
// Assumes: one slave, hready fed back from hreadyout
// Notes: wake delays are counted in hclk edges
`timescale 1ns/1ps
`default_nettype none
module oscillator_force_enable_sleep_ctrl_test;
	import ofe_pkg::*;
	logic hclk = 0;
	logic hresetn = 0;
	logic hsel = 0;
	logic hwrite = 0;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata, rd;
	logic [1:0] htrans = '0;
	logic [5:0] req = '0;
	logic slp = 0;
	logic wk = 0;
	logic hrdy, hresp, use_pwr, reg_en, reg_lp, hold;
	ofe_osc_t osc;
	int num_errors = 0;
	int samples_checked = 0;
	int n;
	always #12.5 hclk = ~hclk;
	ofe_ctrl u_ofe_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
		.hresp(hresp), .periph_osc_req(req), .sleep_req(slp), .wake_req(wk),
		.osc_enable(osc), .secondary_osc_use_power_cfg(use_pwr),
		.regulator_enable(reg_en), .regulator_low_power(reg_lp),
		.core_hold(hold));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task final_report;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
			num_errors++;
		end
	endtask
	// bounded wait; sees values sampled at the edge, before updates land
	task edge_rdy;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hrdy !== 1'b1 && n < 50);
		if (hrdy !== 1'b1) begin
			num_errors++;
			final_report;
		end
	endtask
	task bus(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1;
		haddr <= {20'h0_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		edge_rdy;
		htrans <= 2'h0;
		hsel <= 0;
		hwdata <= d;
		edge_rdy;
		r = hrdata;
	endtask
	task hold_wait(input logic v);
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hold !== v && n < 300);
		if (hold !== v) begin
			num_errors++;
			final_report;
		end
	endtask
	// one sleep and wake round in the given regulator mode
	task nap(input logic [31:0] mode, input logic lp);
		logic [31:0] exp_st;
		exp_st = lp ? 32'(ofe_sleep_lp) : 32'(ofe_sleep_norm);
		bus(ofe_reg_ctrl_off, 1, mode, rd);
		bus(ofe_reg_ctrl_off, 0, '0, rd);
		chk("reg_ctrl", {30'h0000_0000, lp, 1'b0}, rd);
		slp <= 1;
		hold_wait(1);
		slp <= 0;
		chk("low_power", {31'h0000_0000, lp}, reg_lp);
		chk("reg_on_sleep", 32'h0000_0001, reg_en);
		bus(ofe_status_off, 0, '0, rd);
		chk("status_sleep", exp_st, rd);
		wk <= 1;
		hold_wait(0);
		wk <= 0;
		chk("wake_delay", {31'h0000_0000, lp}, n >= ofe_wake_cyc);
		chk("wake_bound", 32'h0000_0001, n < 50);
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		chk("reg_on_reset", 32'h0000_0001, reg_en);
		bus(ofe_osc_force_off, 0, '0, rd);
		chk("force_reset", 32'h0000_0000, rd);
		chk("hresp_okay", 32'h0000_0000, hresp);
		bus(ofe_status_off, 0, '0, rd);
		chk("status_run", 32'(ofe_run), rd);
		bus(ofe_osc_force_off, 1, 32'hffff_ffff, rd);
		bus(ofe_osc_force_off, 0, '0, rd);
		chk("force_mask", 32'h0000_00fc, rd);
		repeat (2) @(posedge hclk);
		chk("osc_forced", 32'h0000_003f, 32'(osc));
		chk("sec_power_cfg", 32'h0000_0001, use_pwr);
		bus(ofe_osc_force_off, 1, '0, rd);
		req <= 6'h15;
		repeat (6) @(posedge hclk);
		chk("osc_request", 32'h0000_0015, 32'(osc));
		chk("sec_power_off", 32'h0000_0000, use_pwr);
		bus(12'h00c, 0, '0, rd);
		chk("unmapped", 32'h0000_0000, rd);
		nap(32'h0000_0000, 0);
		nap(32'hffff_ffff, 1);
		// reset in mid-run must clear both registers again
		bus(ofe_osc_force_off, 1, 32'h0000_00a4, rd);
		hresetn <= 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		chk("osc_after_reset", 32'h0000_0000, 32'(osc));
		chk("lp_after_reset", 32'h0000_0000, reg_lp);
		bus(ofe_osc_force_off, 0, '0, rd);
		chk("force_after_reset", 32'h0000_0000, rd);
		bus(ofe_reg_ctrl_off, 0, '0, rd);
		chk("ctrl_after_reset", 32'h0000_0000, rd);
		final_report;
	end
endmodule
`default_nettype wire
